// [logic/pasl_core.sv]
// Scale and offset, limit test and serial averaging and filter stage.
// Assumes acquisition strobes and the register port share clock_in.
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module pasl_core #(
  parameter int AVG_SHIFT = 3, // Averaging weight as a power of two.
  parameter int CNT_W = 32 // Pass and fail counter width.
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [pasl_pkg::ADDR_W-1:0] addr_in,
  input wire logic [pasl_pkg::VAL_W-1:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [pasl_pkg::VAL_W-1:0] rd_data_out,
  input wire logic acq_done_in,
  input wire logic acq_abort_in,
  input wire logic [pasl_pkg::VAL_W-1:0] acq_value_in,
  input wire logic [3:0] acq_digits_in,
  input wire logic meas_busy_in,
  input wire pasl_pkg::pasl_func_type func_in,
  input wire logic dev_clear_in,
  output pasl_pkg::pasl_resp_type resp_out,
  output logic holdoff_out,
  output logic last_fail_out,
  output logic stage3_valid_out,
  output logic [pasl_pkg::VAL_W-1:0] stage3_value_out
);
  import pasl_pkg::*;

  // ==========================================================
  // Functions.
  // Totalize and voltage peaks skip every post-processing stage.
  function automatic logic is_bypass(input pasl_func_type f);
    return (f == FUNC_TOTALIZE) || (f == FUNC_VMIN) ||
           (f == FUNC_VMAX) || (f == FUNC_VPP);
  endfunction

  // Fixed-point scale and offset; 64 bits keep 15 digits.
  function automatic logic signed [63:0] scale_offset(
    input logic signed [63:0] x,
    input logic signed [63:0] s,
    input logic signed [63:0] o);
    logic signed [127:0] p;
    p = x * s;
    return 64'(p >>> FRAC_W) + o;
  endfunction

  // Combined lower and upper test; equality passes.
  function automatic logic out_of_limits(
    input logic signed [63:0] v,
    input logic signed [63:0] lo,
    input logic signed [63:0] hi);
    return (v < lo) || (v > hi);
  endfunction

  // Digit count is kept inside the printable range.
  function automatic logic [3:0] clamp_digits(input logic [3:0] d);
    return (d < DIG_MIN) ? DIG_MIN : d;
  endfunction

  // ==========================================================
  // State.
  pasl_ctrl_type ctrl_q; // Enables and modes.
  logic signed [63:0] scale_q, offset_q, upper_q, lower_q;
  logic signed [63:0] raw_q; // Last acquired value.
  logic raw_ok_q; // A value has been acquired.
  logic [3:0] digits_q; // Resolution of the last value.
  logic signed [63:0] math_val_q; // Math stage result.
  logic math_valid_q; // Math result may be reported.
  logic lim_valid_q; // Limit result may be reported.
  logic last_fail_q; // Last tested result failed.
  logic [CNT_W-1:0] pass_q, fail_q; // Acquisition-time counts.
  logic recalc_go_q; // Recalculation due this cycle.
  logic done_q; // A measurement ended last cycle.
  pasl_qstate_type qstate_q; // Result query state.
  logic [15:0] err_q; // Last logged error.
  logic signed [63:0] avg_q; // Running averaging_stage.
  logic avg_fill_q; // Averaging_stage has a first sample.
  pasl_resp_type resp_q;
  logic [63:0] rd_q;
  logic s3_valid_q;
  logic [63:0] s3_value_q;

  // ==========================================================
  // Decode.
  logic wr_ok, ctrl_wr, math_wr, lim_wr, cnt_clr, inst_reset;
  logic q_cmd, eq_bad, acq_ok, bypass, run_acq, run_recalc, run_calc;
  logic fail_now, ans_go, ans_nan, hold_go, err_set;
  logic [15:0] err_code;
  logic [63:0] cmd_bits, rd_mux;
  logic signed [63:0] proc_src, proc_val, avg_next;

  // Commands are dropped while a result query is stalled.
  assign wr_ok = wr_en_in && (qstate_q == Q_IDLE);
  assign cmd_bits = (wr_ok && addr_in == OFS_CMD) ? wr_data_in : ZERO_VAL;
  assign ctrl_wr = wr_ok && (addr_in == OFS_CTRL);
  assign math_wr = ctrl_wr || (wr_ok && (addr_in == OFS_SCALE ||
                   addr_in == OFS_OFFSET));
  assign lim_wr = ctrl_wr || (wr_ok && (addr_in == OFS_UPPER ||
                  addr_in == OFS_LOWER));
  assign inst_reset = cmd_bits[CMD_INST_RESET];
  // Any enable write or limit change empties the counts.
  assign cnt_clr = lim_wr || inst_reset;
  assign q_cmd = cmd_bits[CMD_RESULT_QUERY];
  assign eq_bad = cmd_bits[CMD_EQ_QUERY] && !cmd_bits[CMD_MSG_LAST];
  // An abort in the same cycle spoils the value.
  assign acq_ok = acq_done_in && !acq_abort_in;
  assign bypass = is_bypass(func_in);
  assign run_acq = acq_ok && !bypass;
  // A new acquisition takes priority over a pending recalculation.
  assign run_recalc = recalc_go_q && raw_ok_q && !bypass && !acq_ok;
  assign run_calc = run_acq || run_recalc;
  // Math sees the active acquisition, else the stored one; limits see math.
  assign proc_src = acq_ok ? acq_value_in : raw_q;
  assign proc_val = ctrl_q.math_en ?
                    scale_offset(proc_src, scale_q, offset_q) : proc_src;
  assign fail_now = out_of_limits(proc_val, lower_q, upper_q);

  // ==========================================================
  // Query answer and error selection.
  always_comb begin
    ans_go = 1'b0;
    ans_nan = 1'b0;
    hold_go = 1'b0;
    err_set = 1'b0;
    err_code = ERR_NONE;
    if (eq_bad) begin
      err_set = 1'b1;
      err_code = ERR_QUERY_ORDER;
    end
    if (q_cmd || (qstate_q == Q_HOLD && done_q)) begin
      if (bypass) begin
        // The function has no processed result at all.
        ans_go = 1'b1;
        ans_nan = 1'b1;
        err_set = 1'b1;
        err_code = ERR_SETTINGS;
      end else if (q_cmd && ctrl_q.math_en && meas_busy_in) begin
        hold_go = 1'b1;
      end else begin
        ans_go = 1'b1;
        if (!math_valid_q) begin
          // Nothing valid to report.
          ans_nan = 1'b1;
          err_set = 1'b1;
          err_code = ERR_NO_RESULT;
        end
      end
    end
  end

  // ==========================================================
  // Settings; power-up leaves auto on, reset command turns it off.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_q <= CTRL_PWRUP;
      scale_q <= SCALE_ONE;
      offset_q <= ZERO_VAL;
      upper_q <= ZERO_VAL;
      lower_q <= ZERO_VAL;
    end else if (inst_reset) begin
      ctrl_q <= CTRL_RESET;
      scale_q <= SCALE_ONE;
      offset_q <= ZERO_VAL;
      upper_q <= ZERO_VAL;
      lower_q <= ZERO_VAL;
    end else if (wr_ok) begin
      case (addr_in)
        OFS_CTRL: ctrl_q <= pasl_ctrl_type'(wr_data_in[$bits(pasl_ctrl_type)-1:0]);
        OFS_SCALE: scale_q <= wr_data_in;
        OFS_OFFSET: offset_q <= wr_data_in;
        OFS_UPPER: upper_q <= wr_data_in;
        OFS_LOWER: lower_q <= wr_data_in;
        default: ;
      endcase
    end
  end

  // Recalculation one cycle after the command, so new settings apply.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      recalc_go_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      recalc_go_q <= cmd_bits[CMD_RECALC] ||
                     (ctrl_q.auto_recalc && (math_wr || lim_wr));
      done_q <= acq_done_in || acq_abort_in;
    end
  end

  // Stored acquisition, reused by recalculation.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      raw_q <= ZERO_VAL;
      raw_ok_q <= 1'b0;
      digits_q <= DIG_MIN;
    end else if (acq_ok) begin
      raw_q <= acq_value_in;
      raw_ok_q <= 1'b1;
      digits_q <= clamp_digits(acq_digits_in);
    end
  end

  // Math result; a fresh computation wins over an invalidating write.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      math_val_q <= ZERO_VAL;
      math_valid_q <= 1'b0;
    end else if (run_calc) begin
      math_val_q <= proc_val;
      math_valid_q <= 1'b1;
    end else if (math_wr || inst_reset) begin
      math_valid_q <= 1'b0;
    end
  end

  // Last pass or fail status; only used while the limit test is on.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      last_fail_q <= 1'b0;
      lim_valid_q <= 1'b0;
    end else if (run_calc && ctrl_q.limit_en) begin
      last_fail_q <= fail_now;
      lim_valid_q <= 1'b1;
    end else if (lim_wr || inst_reset) begin
      last_fail_q <= 1'b0;
      lim_valid_q <= 1'b0;
    end
  end

  // Counts move only on tested acquisitions; a clear never eats one.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pass_q <= '0;
      fail_q <= '0;
    end else begin
      pass_q <= (cnt_clr ? '0 : pass_q) +
                CNT_W'(run_acq && ctrl_q.limit_en && !fail_now);
      fail_q <= (cnt_clr ? '0 : fail_q) +
                CNT_W'(run_acq && ctrl_q.limit_en && fail_now);
    end
  end

  // ==========================================================
  // Third stage: averaging, then limit filter, on acquisitions only.
  assign avg_next = (!ctrl_q.avg_en || !avg_fill_q) ? proc_val :
                    avg_q + ((proc_val - avg_q) >>> AVG_SHIFT);

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      avg_q <= ZERO_VAL;
      avg_fill_q <= 1'b0;
      s3_valid_q <= 1'b0;
      s3_value_q <= ZERO_VAL;
    end else begin
      s3_valid_q <= 1'b0;
      if (!ctrl_q.avg_en) begin
        avg_fill_q <= 1'b0;
      end
      if (run_acq) begin
        avg_q <= avg_next;
        avg_fill_q <= ctrl_q.avg_en;
        // The filter drops out-of-limit values only when enabled.
        if (!ctrl_q.lfilt_en || !out_of_limits(avg_next, lower_q, upper_q)) begin
          s3_valid_q <= 1'b1;
          s3_value_q <= avg_next;
        end
      end
    end
  end

  // ==========================================================
  // Result query: answer now, or stall until the measurement ends.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      qstate_q <= Q_IDLE;
    end else begin
      case (qstate_q)
        Q_IDLE: begin
          if (hold_go) begin
            qstate_q <= Q_HOLD;
          end
        end
        Q_HOLD: begin
          // Only a measurement end (done or abort) or device clear release the stall.
          if (dev_clear_in || done_q) begin
            qstate_q <= Q_IDLE;
          end
        end
        default: qstate_q <= Q_IDLE;
      endcase
    end
  end

  // Answer strobe with value, digits and format.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      resp_q <= '0;
    end else begin
      resp_q.valid <= ans_go && !(qstate_q == Q_HOLD && dev_clear_in);
      if (ans_go) begin
        resp_q.is_nan <= ans_nan;
        resp_q.value <= ans_nan ? NAN_CODE : math_val_q;
        resp_q.text <= ctrl_q.text_fmt;
        resp_q.digits <= digits_q;
      end
    end
  end

  // Error log: a new error wins over the clear by reading it.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      err_q <= ERR_NONE;
    end else if (err_set) begin
      err_q <= err_code;
    end else if (rd_en_in && addr_in == OFS_ERROR) begin
      err_q <= ERR_NONE;
    end
  end

  // ==========================================================
  // Register read, data one cycle after the strobe, zero otherwise.
  always_comb begin
    rd_mux = ZERO_VAL;
    case (addr_in)
      OFS_CTRL: rd_mux[$bits(pasl_ctrl_type)-1:0] = ctrl_q;
      OFS_SCALE: rd_mux = scale_q;
      OFS_OFFSET: rd_mux = offset_q;
      OFS_UPPER: rd_mux = upper_q;
      OFS_LOWER: rd_mux = lower_q;
      OFS_STATUS: begin
        rd_mux[ST_MATH_VALID] = math_valid_q;
        rd_mux[ST_LIM_VALID] = lim_valid_q;
        rd_mux[ST_LAST_FAIL] = last_fail_q;
        rd_mux[ST_HOLD] = (qstate_q == Q_HOLD);
        rd_mux[ST_RAW_OK] = raw_ok_q;
      end
      OFS_ERROR: rd_mux[15:0] = err_q;
      OFS_PASS: rd_mux[CNT_W-1:0] = pass_q;
      OFS_FAIL: rd_mux[CNT_W-1:0] = fail_q;
      OFS_ENABLES: begin
        // One ASCII byte per enable, lowest byte is math.
        for (int i = 0; i < $bits(pasl_ctrl_type); i++) begin
          rd_mux[i*8 +: 8] = ASCII_ZERO + 8'(ctrl_q[i]);
        end
      end
      OFS_RESULT: rd_mux = math_val_q;
      default: rd_mux = ZERO_VAL;
    endcase
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rd_q <= ZERO_VAL;
    end else begin
      rd_q <= rd_en_in ? rd_mux : ZERO_VAL;
    end
  end

  assign rd_data_out = rd_q;
  assign resp_out = resp_q;
  assign holdoff_out = (qstate_q == Q_HOLD);
  assign last_fail_out = last_fail_q;
  assign stage3_valid_out = s3_valid_q;
  assign stage3_value_out = s3_value_q;

  // ==========================================================
  // Assertions.
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  property p_math_off;
    run_acq && !ctrl_q.math_en |=> math_val_q == $past(acq_value_in);
  endproperty
  a_math_off: assert property (p_math_off)
    else $error("Math off did not pass the value through.");

  property p_scale;
    run_acq && ctrl_q.math_en |=>
      math_val_q == scale_offset($past(acq_value_in), $past(scale_q), $past(offset_q));
  endproperty
  a_scale: assert property (p_scale)
    else $error("Scaled result is wrong.");

  property p_no_result;
    q_cmd && !bypass && !hold_go && !math_valid_q |=>
      resp_q.valid && resp_q.is_nan && err_q == ERR_NO_RESULT;
  endproperty
  a_no_result: assert property (p_no_result)
    else $error("Missing result did not give the sentinel.");

  property p_bypass_query;
    q_cmd && bypass |=> resp_q.is_nan && err_q == ERR_SETTINGS;
  endproperty
  a_bypass_query: assert property (p_bypass_query)
    else $error("Bypassed query did not give the sentinel.");

  property p_hold;
    q_cmd && !bypass && ctrl_q.math_en && meas_busy_in |=>
      holdoff_out && !resp_q.valid;
  endproperty
  a_hold: assert property (p_hold)
    else $error("Busy query was answered at once.");

  property p_holdoff_writes;
    holdoff_out && wr_en_in |=> $stable(ctrl_q) && $stable(scale_q) && $stable(offset_q);
  endproperty
  a_holdoff_writes: assert property (p_holdoff_writes)
    else $error("Write taken during hold-off.");

  property p_cnt_clear;
    ctrl_wr && !run_acq |=> pass_q == '0 && fail_q == '0;
  endproperty
  a_cnt_clear: assert property (p_cnt_clear)
    else $error("Enable write left counts.");

  property p_recalc_counts;
    !run_acq && !cnt_clr |=> $stable(pass_q) && $stable(fail_q);
  endproperty
  a_recalc_counts: assert property (p_recalc_counts)
    else $error("Counts moved without acquisition.");

  property p_abort;
    acq_abort_in && !recalc_go_q && !lim_wr && !inst_reset |=>
      $stable(last_fail_q) && $stable(lim_valid_q);
  endproperty
  a_abort: assert property (p_abort)
    else $error("Abort changed the limit result.");

  property p_equal_limit;
    run_acq && ctrl_q.limit_en && (proc_val == upper_q || proc_val == lower_q)
      |=> !last_fail_q;
  endproperty
  a_equal_limit: assert property (p_equal_limit)
    else $error("Value equal to a limit failed.");

  property p_reset_auto;
    inst_reset |=> !ctrl_q.auto_recalc;
  endproperty
  a_reset_auto: assert property (p_reset_auto)
    else $error("Reset left auto recalculate on.");

  c_hold_release: cover property (holdoff_out ##1 !holdoff_out && resp_q.valid);
  c_recalc: cover property (run_recalc ##1 math_valid_q);
  c_fail: cover property (run_acq && ctrl_q.limit_en && fail_now);
  c_eq_bad: cover property (eq_bad ##1 err_q == ERR_QUERY_ORDER);
endmodule
`default_nettype wire

// [logic/pasl_pkg.sv]
// Constants, types and register map of the scale, offset and limit stage.
// Assumes a 64-bit plain register port and a 100 MHz single clock.
package pasl_pkg;
  // ==========================================================
  // Widths.
  localparam int VAL_W = 64; // Signed value width.
  localparam int FRAC_W = 32; // Fraction bits of the scale.
  localparam int ADDR_W = 8; // Register address width.
  // ==========================================================
  // Register offsets (byte addresses, one 64-bit word each).
  localparam logic [7:0] OFS_CTRL = 8'h00; // Enables and modes.
  localparam logic [7:0] OFS_SCALE = 8'h08; // Scale factor.
  localparam logic [7:0] OFS_OFFSET = 8'h10; // Offset.
  localparam logic [7:0] OFS_UPPER = 8'h18; // Upper limit.
  localparam logic [7:0] OFS_LOWER = 8'h20; // Lower limit.
  localparam logic [7:0] OFS_CMD = 8'h28; // Command strobes.
  localparam logic [7:0] OFS_STATUS = 8'h30; // Valid flags.
  localparam logic [7:0] OFS_ERROR = 8'h38; // Last error code.
  localparam logic [7:0] OFS_PASS = 8'h40; // Pass count.
  localparam logic [7:0] OFS_FAIL = 8'h48; // Fail count.
  localparam logic [7:0] OFS_ENABLES = 8'h50; // Enables as text.
  localparam logic [7:0] OFS_RESULT = 8'h58; // Last result.
  // ==========================================================
  // Command bits and status bits.
  localparam int CMD_RECALC = 0; // Recalculate now.
  localparam int CMD_INST_RESET = 1; // Instrument reset.
  localparam int CMD_RESULT_QUERY = 2; // Processed result query.
  localparam int CMD_EQ_QUERY = 3; // Equation query.
  localparam int CMD_MSG_LAST = 4; // Query ends its message.
  localparam int ST_MATH_VALID = 0;
  localparam int ST_LIM_VALID = 1;
  localparam int ST_LAST_FAIL = 2;
  localparam int ST_HOLD = 3;
  localparam int ST_RAW_OK = 4;
  // ==========================================================
  // Values.
  localparam logic [63:0] SCALE_ONE = 64'h0000_0001_0000_0000;
  localparam logic [63:0] NAN_CODE = 64'h7fff_ffff_ffff_ffff;
  localparam logic [63:0] ZERO_VAL = 64'h0000_0000_0000_0000;
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_NO_RESULT = 16'hff1a; // Code -230.
  localparam logic [15:0] ERR_SETTINGS = 16'hff23; // Code -221.
  localparam logic [15:0] ERR_QUERY_ORDER = 16'hfe48; // Code -440.
  localparam logic [3:0] DIG_MIN = 4'h1;
  localparam logic [3:0] DIG_MAX = 4'hf;
  localparam logic [7:0] ASCII_ZERO = 8'h30;
  // ==========================================================
  // Types.
  typedef struct packed {
    logic text_fmt; // One selects exponent text output.
    logic auto_recalc; // Recalculate on every setting change.
    logic lfilt_en; // Limit filter sub-block enable.
    logic avg_en; // Averaging sub-block enable.
    logic limit_en; // Limit test enable.
    logic math_en; // Scale and offset enable.
  } pasl_ctrl_type;
  localparam pasl_ctrl_type CTRL_PWRUP = 6'h30;
  localparam pasl_ctrl_type CTRL_RESET = 6'h20;
  typedef enum logic [2:0] {
    FUNC_FREQ = 3'h0, FUNC_PERIOD = 3'h1, FUNC_TOTALIZE = 3'h2,
    FUNC_VMIN = 3'h3, FUNC_VMAX = 3'h4, FUNC_VPP = 3'h5, FUNC_OTHER = 3'h6
  } pasl_func_type;
  typedef enum logic [1:0] {Q_IDLE = 2'b00, Q_HOLD = 2'b01} pasl_qstate_type;
  typedef struct packed {
    logic valid; // One-cycle answer strobe.
    logic is_nan; // Answer is the not-a-number sentinel.
    logic text; // Answer is in exponent text format.
    logic [3:0] digits; // Significant digits to print.
    logic [63:0] value; // Answer value.
  } pasl_resp_type;
endpackage

// [bench/pasl_front_model.sv]
// Measurement front-end model feeding the acquisition side of the stage.
// Assumes one clock shared with the block; go_in starts one measurement.
`timescale 1ns/1ps
`default_nettype none
module pasl_front_model #(
  parameter int LAT = 10 // Measurement length in cycles.
) (
  input wire logic clock_in,
  input wire logic go_in,
  input wire logic [63:0] val_in,
  output var logic busy_out = 1'b0,
  output var logic done_out = 1'b0,
  output logic [63:0] value_out,
  output logic [3:0] digits_out
);
  int cnt = 0; // Cycles left in the running measurement.
  logic [63:0] last_q = 64'h0; // Value of the running measurement.
  // ==========================================================
  // Busy for LAT cycles, then one done pulse with the value.
  always @(posedge clock_in) begin
    done_out <= 1'b0;
    if (go_in) begin
      busy_out <= 1'b1;
      cnt <= LAT;
      last_q <= val_in;
    end else if (busy_out && cnt == 1) begin
      busy_out <= 1'b0;
      done_out <= 1'b1;
    end else if (busy_out) begin
      cnt <= cnt - 1;
    end
  end
  // Outside the done pulse the lines carry junk, so stale data is never reused.
  assign value_out = done_out ? last_q : ~last_q;
  assign digits_out = done_out ? 4'h9 : 4'h6;
endmodule
`default_nettype wire

// [bench/post_acquisition_scale_limit_tb_top.sv]
// Bench top: drives the register port and queues expected reads and answers.
// Assumes pasl_front_model stands in for the acquisition side.
`timescale 1ns/1ps
`default_nettype none
module post_acquisition_scale_limit_tb_top;
  import pasl_pkg::*;
  logic clock_in = 1'b0, rst_in = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
  logic go = 1'b0, ab = 1'b0, rd_dly = 1'b0, busy, done, hold, lfail, s3v;
  logic [7:0] addr = 8'h00;
  logic [63:0] wdata = 64'h0, gval = 64'h0, rdata, aval, s3val, sexp;
  logic [3:0] adig;
  pasl_func_type func = FUNC_FREQ;
  pasl_resp_type resp;
  logic [63:0] rq[$], sq[$]; // Expected read data and query answers.
  int fails = 0, comparisons = 0, s3n = 0; // s3n counts third-stage pulses.
  longint a, s, o;
  initial forever #5 clock_in = ~clock_in;
  pasl_front_model i_pasl_front_model (.clock_in(clock_in), .go_in(go), .val_in(gval),
    .busy_out(busy), .done_out(done), .value_out(aval), .digits_out(adig));
  pasl_core i_pasl_core (.clock_in(clock_in), .rst_in(rst_in), .addr_in(addr),
    .wr_data_in(wdata), .wr_en_in(wr_en), .rd_en_in(rd_en), .rd_data_out(rdata),
    .acq_done_in(done), .acq_abort_in(ab), .acq_value_in(aval), .acq_digits_in(adig),
    .meas_busy_in(busy), .func_in(func), .dev_clear_in(1'b0), .resp_out(resp),
    .holdoff_out(hold), .last_fail_out(lfail), .stage3_valid_out(s3v),
    .stage3_value_out(s3val));
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // A strobe is one cycle wide; the task leaves a free cycle behind it.
  task automatic wr(input logic [7:0] a_i, input logic [63:0] d_i);
    @(posedge clock_in);
    addr <= a_i;
    wdata <= d_i;
    wr_en <= 1'b1;
    @(posedge clock_in);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a_i, input logic [63:0] e_i);
    rq.push_back(e_i);
    @(posedge clock_in);
    addr <= a_i;
    rd_en <= 1'b1;
    @(posedge clock_in);
    rd_en <= 1'b0;
  endtask
  task automatic start(input logic [63:0] v);
    @(posedge clock_in);
    go <= 1'b1;
    gval <= v;
    @(posedge clock_in);
    go <= 1'b0;
  endtask
  // Bounded wait until the front end is idle and no query is stalled.
  task automatic settle();
    int n;
    // Busy rises only after the start edge, so one edge passes before looking.
    @(posedge clock_in);
    for (n = 0; n < 40 && (busy !== 1'b0 || hold !== 1'b0); n++) @(posedge clock_in);
    if (n == 40) begin
      fails++;
      stop_test();
    end
    repeat (2) @(posedge clock_in);
  endtask
  // ==========================================================
  // Monitor: read data stands one cycle after the strobe, answers as pulses.
  always @(posedge clock_in) rd_dly <= rd_en;
  always @(negedge clock_in) begin
    if (rd_dly) check(rdata, rq.size() > 0 ? rq.pop_front() : ~rdata);
    if (s3v === 1'b1) s3n++;
    if (resp.valid === 1'b1) begin
      sexp = sq.size() > 0 ? sq.pop_front() : ~resp.value;
      check(resp.value, sexp);
      check(resp.is_nan, sexp == NAN_CODE);
      // Real answers follow acquisitions of nine digits with text output on.
      if (sexp != NAN_CODE) check({resp.text, resp.digits}, 5'h19);
    end
  end
  initial begin
    void'($urandom(32'hf78ad159));
    repeat (12) @(posedge clock_in);
    rst_in <= 1'b0;
    rd(OFS_CTRL, 64'(CTRL_PWRUP));
    rd(OFS_ENABLES, 64'h0000_3131_3030_3030);
    sq.push_back(NAN_CODE);
    wr(OFS_CMD, 64'h4);
    rd(OFS_ERROR, 64'(ERR_NO_RESULT));
    s = longint'($urandom % 32'h0fff_ffff) << 8;
    o = longint'($urandom % 1000) - 500;
    a = longint'($urandom % 100000);
    wr(OFS_SCALE, s);
    wr(OFS_OFFSET, o);
    wr(OFS_CTRL, 64'h21);
    start(a);
    settle();
    sq.push_back(((a * s) >>> 32) + o);
    wr(OFS_CMD, 64'h4);
    wr(OFS_CTRL, 64'h20);
    sq.push_back(NAN_CODE);
    wr(OFS_CMD, 64'h4);
    wr(OFS_CMD, 64'h1);
    sq.push_back(a);
    wr(OFS_CMD, 64'h4);
    wr(OFS_UPPER, a);
    wr(OFS_LOWER, a - 1);
    wr(OFS_CTRL, 64'h22);
    start(a);
    settle();
    check(lfail, 1'b0);
    start(a + 1);
    settle();
    check(lfail, 1'b1);
    ab <= 1'b1;
    @(posedge clock_in);
    ab <= 1'b0;
    wr(OFS_CMD, 64'h1);
    rd(OFS_PASS, 64'h1);
    rd(OFS_FAIL, 64'h1);
    wr(OFS_CTRL, 64'h22);
    rd(OFS_PASS, 64'h0);
    wr(OFS_CTRL, 64'h24);
    start(a);
    settle();
    start(a + 16);
    settle();
    check(s3val, a + 2);
    for (int f = 2; f < 6; f++) begin
      func <= pasl_func_type'(f);
      sq.push_back(NAN_CODE);
      wr(OFS_CMD, 64'h4);
      rd(OFS_ERROR, 64'(ERR_SETTINGS));
    end
    func <= FUNC_FREQ;
    wr(OFS_CTRL, 64'h21);
    start(a + 7);
    sq.push_back((((a + 7) * s) >>> 32) + o);
    wr(OFS_CMD, 64'h4);
    @(negedge clock_in);
    check(hold, 1'b1);
    wr(OFS_OFFSET, 64'h0);
    settle();
    wr(OFS_CMD, 64'h8);
    rd(OFS_ERROR, 64'(ERR_QUERY_ORDER));
    wr(OFS_CMD, 64'h18);
    rd(OFS_ERROR, 64'(ERR_NONE));
    wr(OFS_CMD, 64'h2);
    rd(OFS_CTRL, 64'(CTRL_RESET));
    wr(OFS_CTRL, 64'h31);
    wr(OFS_OFFSET, 64'h5);
    sq.push_back(a + 12);
    wr(OFS_CMD, 64'h4);
    repeat (4) @(posedge clock_in);
    check(s3n, 6);
    if (rq.size() + sq.size() > 0) fails++;
    stop_test();
  end
endmodule
`default_nettype wire
